// ### core/serial_eeprom_rw_engine.sv
// Purpose: two-wire eeprom slave: byte/page write, polling, protect, reads
// Assumes: scl, sda and protect pins are asynchronous to clk
// Notes:   array contents are flip-flops without reset
`timescale 1ns/1ps
module serial_eeprom_rw_engine
    import eeprom_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE  = 4'h6,       // type code, value arbitrary
    parameter int         WR_CNT    = WR_CYCLES,  // programming length in cycles
    parameter int         FIFO_DEP  = FIFO_DEPTH  // receive fifo depth
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // two-wire bus pins
    input  wire logic scl_pin,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // protect pin
    input  wire logic wp_pin,
    // status
    output logic      busy
);
    localparam int WR_W = $clog2(WR_CNT + 1);

    // synchronisers and edge history
    logic scl_meta, scl_s, scl_d;     // clock pin
    logic sda_meta, sda_s, sda_d;     // data pin
    logic wp_meta, wp_s;              // protect pin
    // protocol engine
    eng_state_t        state;         // current protocol phase
    logic [3:0]        bit_cnt;       // scl rises in this byte frame
    logic [6:0]        shift;         // received bits so far
    logic              ack_flag;      // ack decided for ninth clock
    logic              dev_rw;        // rw bit of the last devaddr
    logic [2:0]        addr_hi;       // upper address from devaddr
    logic [ADDR_W-1:0] addr_cnt;      // internal address counter
    logic [DATA_W-1:0] tx;            // byte being sent
    logic              wrote;         // data bytes taken this session
    // programming
    logic [WR_W-1:0]   wr_timer;      // remaining programming cycles
    logic              commit;        // one-cycle array update
    // page buffer
    logic [DATA_W-1:0]     pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask;     // bytes loaded in the row
    logic [6:0]            prow;      // row of the loaded bytes
    logic [DATA_W-1:0]     mem  [MEM_BYTES];
    // fifo links
    wr_entry_t fifo_in;
    wr_entry_t fifo_out;
    logic      fifo_in_valid, fifo_in_ready;
    logic      fifo_out_valid, fifo_out_ready;
    // decoded events
    logic              scl_rise, scl_fall, start_ev, stop_ev, active;
    logic              byte_done, ack_clk, dev_match, ack_now, master_ack;
    logic              load_tx, prog_req, discard;
    logic [DATA_W-1:0] rx_byte;

    // two flip-flops on every pin, then a history stage on scl and sda for edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            scl_d    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_d    <= 1'b1;
            wp_meta  <= 1'b0;
            wp_s     <= 1'b0;
        end else begin
            scl_meta <= scl_pin;
            scl_s    <= scl_meta;
            scl_d    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_d    <= sda_s;
            wp_meta  <= wp_pin;
            wp_s     <= wp_meta;
        end
    end

    // while programming every bus event is dropped
    assign active     = !busy;
    assign scl_rise   = active & scl_s & !scl_d;
    assign scl_fall   = active & !scl_s & scl_d;
    assign start_ev   = active & scl_s & scl_d & sda_d & !sda_s;
    assign stop_ev    = active & scl_s & scl_d & !sda_d & sda_s;
    assign rx_byte    = {shift, sda_s};
    assign byte_done  = scl_rise & (bit_cnt == BIT_LAST)
                        & (state != ST_IDLE) & (state != ST_RDATA);
    assign ack_clk    = scl_rise & (bit_cnt == BIT_ACK) & (state != ST_IDLE);
    assign dev_match  = (rx_byte[DA_TYPE_HI:DA_TYPE_LO] == DEV_TYPE);
    assign master_ack = !sda_s;

    // ack choice at the eighth bit; a full fifo refuses the data byte
    always_comb begin
        unique case (state)
            ST_DEV:   ack_now = dev_match;
            ST_WORD:  ack_now = 1'b1;
            ST_WDATA: ack_now = fifo_in_ready;
            default:  ack_now = 1'b0;
        endcase
    end

    // a new read byte is fetched after devaddr ack or a master ack
    assign load_tx = ack_clk & ((state == ST_DEV) & ack_flag & dev_rw
                     | (state == ST_RDATA) & master_ack);
    // stop after data decides programming from the protect pin
    assign prog_req = stop_ev & wrote & !wp_s;
    assign discard  = (stop_ev & wrote & wp_s) | (start_ev & wrote);

    // received data goes to the fifo with its target address
    assign fifo_in_valid = byte_done & (state == ST_WDATA);
    assign fifo_in       = '{addr: addr_cnt, data: rx_byte};
    // the page buffer stops draining while a cycle runs
    assign fifo_out_ready = !busy;

    // protocol phase and bit framing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            shift    <= 7'h00;
            ack_flag <= 1'b0;
            dev_rw   <= 1'b0;
        end else if (start_ev) begin
            // every command opens at a start
            state    <= ST_DEV;
            bit_cnt  <= 4'h0;
            ack_flag <= 1'b0;
        end else if (stop_ev) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            ack_flag <= 1'b0;
        end else if (ack_clk) begin
            // ninth clock: move on or fall back to standby
            bit_cnt <= 4'h0;
            unique case (state)
                ST_DEV: begin
                    if (!ack_flag) begin
                        state <= ST_IDLE;
                    end else if (dev_rw) begin
                        state <= ST_RDATA;
                    end else begin
                        state <= ST_WORD;
                    end
                end
                ST_WORD:  state <= ST_WDATA;
                ST_WDATA: state <= ST_WDATA;
                ST_RDATA: state <= master_ack ? ST_RDATA : ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end else if (scl_rise & (state != ST_IDLE)) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= rx_byte[6:0];
            if (byte_done) begin
                ack_flag <= ack_now;
                if (state == ST_DEV) begin
                    dev_rw <= rx_byte[DA_RW];
                end
            end
        end
    end

    // address counter and upper address bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_cnt <= ADDR_RST;
            addr_hi  <= 3'h0;
        end else if (byte_done) begin
            unique case (state)
                ST_DEV: begin
                    // read devaddr keeps the dummy-write address
                    if (dev_match & !rx_byte[DA_RW]) begin
                        addr_hi <= rx_byte[DA_ADDR_HI:DA_ADDR_LO];
                    end
                end
                ST_WORD:  addr_cnt <= {addr_hi, rx_byte};
                ST_WDATA: begin
                    if (fifo_in_ready) begin
                        // row bits hold, low nibble rolls within the page
                        addr_cnt <= {addr_cnt[10:4], addr_cnt[3:0] + 4'h1};
                    end
                end
                default:  addr_cnt <= addr_cnt;
            endcase
        end else if (load_tx) begin
            // eleven-bit increment wraps from the top to zero
            addr_cnt <= addr_cnt + 11'h001;
        end
    end

    // byte to send on a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx <= BYTE_RST;
        end else if (load_tx) begin
            tx <= mem[addr_cnt];
        end
    end

    // open-drain data output, changed only while scl is low
    assign sda_out = 1'b0;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sda_oe <= 1'b0;
        end else if (busy | start_ev | stop_ev) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            if ((state == ST_RDATA) & (bit_cnt < BIT_ACK)) begin
                // msb first; a one releases the line
                sda_oe <= !tx[3'(BIT_LAST[2:0] - bit_cnt[2:0])];
            end else if ((state != ST_IDLE) & (state != ST_RDATA)
                         & (bit_cnt == BIT_ACK)) begin
                sda_oe <= ack_flag;
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // session flag: data bytes were taken since the last start or stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrote <= 1'b0;
        end else if (start_ev | stop_ev) begin
            wrote <= 1'b0;
        end else if (fifo_in_valid & fifo_in_ready) begin
            wrote <= 1'b1;
        end
    end

    // self-timed programming cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy     <= 1'b0;
            wr_timer <= '0;
            commit   <= 1'b0;
        end else begin
            commit <= 1'b0;
            if (prog_req) begin
                busy     <= 1'b1;
                wr_timer <= WR_W'(WR_CNT - 1);
            end else if (busy) begin
                if (wr_timer == '0) begin
                    // array changes only as the cycle ends
                    busy   <= 1'b0;
                    commit <= 1'b1;
                end else begin
                    wr_timer <= wr_timer - 1'b1;
                end
            end
        end
    end

    // page buffer collects one row between start and stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pmask <= '0;
            prow  <= 7'h00;
        end else if (commit | discard) begin
            pmask <= '0;
        end else if (fifo_out_valid & fifo_out_ready) begin
            // a rolled-over byte overwrites the earlier one
            pmask[fifo_out.addr[3:0]] <= 1'b1;
            prow                      <= fifo_out.addr[10:4];
        end
    end

    // page buffer data has no reset; the mask qualifies it
    always_ff @(posedge clk) begin
        if (fifo_out_valid & fifo_out_ready) begin
            pbuf[fifo_out.addr[3:0]] <= fifo_out.data;
        end
    end

    // nonvolatile array: written once per programming cycle
    always_ff @(posedge clk) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (commit & pmask[i]) begin
                mem[{prow, 4'(i)}] <= pbuf[i];
            end
        end
    end

    // receive fifo between the bit engine and the page buffer
    byte_fifo #(
        .WIDTH ($bits(wr_entry_t)),
        .DEPTH (FIFO_DEP)
    ) rx_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );
endmodule : serial_eeprom_rw_engine

// ### core/eeprom_pkg.sv
// Purpose: shared constants and types of the two-wire eeprom command engine
// Assumes: one 10 MHz clock, pins sampled through two flip-flops
// Notes:   timing counts derive from the clock period below
// Function
// - eleven-bit address from devaddr and word bytes
// - byte write acked, stop starts programming
// - ignore bus entirely while programming runs
// - page write takes 1 to 16 bytes, one row
// - up to fifteen more bytes, each acked
// - only low four address bits advance in writes
// - polling devaddr nacked while busy, acked after
// - no array access during write cycle
// - protect pin high blocks all writes
// - protect pin sampled at stop only
// - protected write still acked, no programming
// - reads use rw bit one, three forms
// - address counter holds last address plus one
// - read past top wraps to zero
// - current read sends byte at counter
// - master nack ends read, back to standby
// - read devaddr upper address bits ignored
// - master ack continues sequential read, wrapping
// - devaddr: type bits 7..4, address 3..1, rw 0
// - type mismatch: no ack, back to standby
// - word byte gives low eight address bits
package eeprom_pkg;
    localparam int ADDR_W     = 11;        // array address width
    localparam int DATA_W     = 8;         // byte width
    localparam int MEM_BYTES  = 2048;      // array size
    localparam int PAGE_BYTES = 16;        // bytes in one row
    localparam int FIFO_DEPTH = 4;         // receive fifo depth
    // timing: longest time rounds down to whole cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WR_NS       = 5000000;
    localparam int WR_CYCLES     = T_WR_NS / CLK_PERIOD_NS;
    // bit counter positions within a byte frame
    localparam logic [3:0] BIT_LAST = 4'h7;   // eighth data bit
    localparam logic [3:0] BIT_ACK  = 4'h8;   // ninth (acknowledge) clock
    // device address byte fields
    localparam int DA_TYPE_HI = 7;
    localparam int DA_TYPE_LO = 4;
    localparam int DA_ADDR_HI = 3;
    localparam int DA_ADDR_LO = 1;
    localparam int DA_RW      = 0;
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

    // one received write byte with its target address
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_entry_t;

    // protocol engine states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b0_0001,
        ST_DEV   = 5'b0_0010,
        ST_WORD  = 5'b0_0100,
        ST_WDATA = 5'b0_1000,
        ST_RDATA = 5'b1_0000
    } eng_state_t;
endpackage : eeprom_pkg

// ### core/byte_fifo.sv
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: single clock, no simultaneous reset of contents needed
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];   // entries
    logic [PW-1:0]    wr_ptr;          // next slot to fill
    logic [PW-1:0]    rd_ptr;          // oldest entry
    logic [PW:0]      count;           // occupancy
    logic             push;
    logic             pop;

    // compare at count width; a pointer-width cast of the depth would be zero
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers wrap at depth; count runs from zero up to depth
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // storage carries no reset; out_valid guards it
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule : byte_fifo

// ### verification/tw_master.sv
// Purpose: two-wire bus master model for the eeprom engine
// Assumes: sda has a pull-up; the master only ever pulls it low
// Notes:   8 clk phases keep the 4 clk setup and hold margins
`timescale 1ns/1ps
module tw_master (
    // clock
    input  wire logic clk,
    // bus side
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // wait n edges, then step just off the edge
    task automatic hw(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hw

    // one bit out; the line is read at the end of the high phase
    task automatic bit_x(input logic b, output logic r);
        hw(4);
        sda_low = !b;
        hw(4);
        scl = 1'b1;
        hw(8);
        r = sda;
        scl = 1'b0;
    endtask : bit_x

    // start, also usable as repeated start from the low phase
    task automatic start();
        hw(4);
        sda_low = 1'b0;
        hw(4);
        scl = 1'b1;
        hw(8);
        sda_low = 1'b1;
        hw(8);
        scl = 1'b0;
    endtask : start

    // stop leaves scl and sda high, the idle state
    task automatic stop();
        hw(4);
        sda_low = 1'b1;
        hw(4);
        scl = 1'b1;
        hw(8);
        sda_low = 1'b0;
        hw(8);
    endtask : stop

    // byte out msb first; ack is the device holding sda low
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte

    // byte in; nack in the ninth clock ends a read
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!ack, r);
    endtask : rbyte

    // bus idle at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
endmodule : tw_master

// ### verification/eeprom_checker.sv
// Purpose: pin level assertions for the eeprom engine
// Assumes: pins are raw, device output lags the scl fall by 3 clk
// Notes:   stop is decoded here from the resolved sda level
`timescale 1ns/1ps
module eeprom_checker #(
    parameter int WR_CNT = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp_pin,
    input wire logic busy
);
    logic scl_q;      // previous scl
    logic sda_q;      // previous sda
    logic stop_ev;    // sda rise with scl high
    int   since_stop; // cycles since last stop, saturating
    int   bcnt;       // length of the current busy run

    assign stop_ev = scl_pin && scl_q && sda_in && !sda_q;

    // pin history for the stop decode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_pin;
            sda_q <= sda_in;
        end
    end

    // distance from stop, and busy length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since_stop <= 255;
            bcnt <= 0;
        end else begin
            since_stop <= stop_ev ? 0 : (since_stop < 255 ? since_stop + 1 : 255);
            bcnt <= busy ? bcnt + 1 : 0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    rst_quiet_a: assert property ($rose(nrst) |-> !sda_oe && !busy)
        else $error("outputs active right after reset");
    busy_silent_a: assert property (busy |-> !sda_oe)
        else $error("device drives sda while programming");
    busy_len_a: assert property ($fell(busy) |-> bcnt == WR_CNT)
        else $error("programming length differs from the cycle count");
    busy_cause_a: assert property ($rose(busy) |-> since_stop <= 8)
        else $error("programming began without a recent stop");
    protect_a: assert property (stop_ev && wp_pin && !busy |=> !busy [*8])
        else $error("protected write started programming");
    busy_steady_a: assert property ($rose(busy) |=> busy [*8])
        else $error("programming cut short");
    oe_low_phase_a: assert property ($changed(sda_oe) |-> !scl_pin && !$past(scl_pin, 2))
        else $error("sda drive changed outside the scl low phase");
    oe_high_stable_a: assert property (scl_pin && $past(scl_pin) |-> $stable(sda_oe))
        else $error("sda drive changed while scl high");
endmodule : eeprom_checker

// ### verification/test_serial_eeprom_rw_engine.sv
// Purpose: self-checking bench for the eeprom engine
// Assumes: master model drives scl and pulls sda, sda has a pull-up
// Notes:   programming shortened to WR_T clk so polling sees it busy
`timescale 1ns/1ps
module test_serial_eeprom_rw_engine;
    import eeprom_pkg::*;
    localparam logic [3:0] TYPE_ID = 4'h6; // type code, value arbitrary
    localparam int         WR_T    = 400;  // longer than one poll byte
    logic clk, nrst, scl, m_low, sda, sda_out, sda_oe, wp, busy;
    int   failures, n_tests;

    // open-drain wire: any puller wins, else pull-up
    assign sda = !(m_low || (sda_oe && !sda_out));

    serial_eeprom_rw_engine #(.DEV_TYPE(TYPE_ID), .WR_CNT(WR_T), .FIFO_DEP(FIFO_DEPTH))
        serial_eeprom_rw_engine_i (.clk(clk), .nrst(nrst), .scl_pin(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp), .busy(busy));
    tw_master tw_master_i (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));

    always #50 clk = ~clk;

    task automatic finish_test();
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk_bit

    function automatic logic [7:0] dev(input logic [10:0] a, input logic rw);
        return {TYPE_ID, a[10:8], rw};
    endfunction : dev

    // start, write-type device byte, word byte
    task automatic addr_ph(input logic [10:0] a);
        logic ack;
        tw_master_i.start();
        tw_master_i.wbyte(dev(a, 1'b0), ack);
        chk_bit(ack, 1'b1, "device byte ack");
        tw_master_i.wbyte(a[7:0], ack);
        chk_bit(ack, 1'b1, "word byte ack");
    endtask : addr_ph

    // byte or page write closed by stop
    task automatic wr(input logic [10:0] a, input logic [7:0] d[$]);
        logic ack;
        addr_ph(a);
        foreach (d[i]) begin
            tw_master_i.wbyte(d[i], ack);
            chk_bit(ack, 1'b1, "data ack");
        end
        tw_master_i.stop();
    endtask : wr

    // poll with matching upper bits until acked, bounded
    task automatic poll(input logic [10:0] a, input logic first_nack);
        logic ack;
        for (int k = 0; k < 10; k++) begin
            tw_master_i.start();
            tw_master_i.wbyte(dev(a, 1'b0), ack);
            tw_master_i.stop();
            if (k == 0) chk_bit(!ack, first_nack, "first poll answer");
            if (ack) return;
        end
        failures++;
        $display("[FAIL] %0t polling never acked", $time);
        finish_test();
    endtask : poll

    // read from the counter; the upper bits sent in the device byte must not matter
    task automatic rd(input logic [10:0] a, input logic [7:0] e[$]);
        logic       ack;
        logic [7:0] d;
        tw_master_i.start();
        tw_master_i.wbyte(dev(a, 1'b1), ack);
        chk_bit(ack, 1'b1, "read device ack");
        foreach (e[i]) begin
            tw_master_i.rbyte(i < e.size() - 1, d);
            chk_byte(d, e[i], "read data");
        end
    endtask : rd

    // byte write, busy during programming, random read back
    task automatic t_byte();
        wr(11'h5A2, {8'hC3});
        poll(11'h5A2, 1'b1);
        addr_ph(11'h5A2);
        rd(~11'h5A2, {8'hC3});
        tw_master_i.stop();
    endtask : t_byte

    // full page from offset e: low nibble wraps inside the row
    task automatic t_page();
        logic [7:0] q[$];
        logic [7:0] e[$];
        for (int i = 0; i < PAGE_BYTES; i++) begin
            q.push_back(8'h40 + 8'(i));
            e.push_back(8'h40 + 8'((i + 2) % PAGE_BYTES));
        end
        wr(11'h13E, q);
        poll(11'h13E, 1'b1);
        rd(11'h13E, {8'h40});
        addr_ph(11'h130);
        rd(11'h130, e);
        tw_master_i.stop();
    endtask : t_page

    // sequential read across the top of the array
    task automatic t_wrap();
        wr(11'h7FF, {8'hE7});
        poll(11'h7FF, 1'b1);
        wr(11'h000, {8'h18});
        poll(11'h000, 1'b1);
        addr_ph(11'h7FF);
        rd(11'h000, {8'hE7, 8'h18});
        tw_master_i.stop();
    endtask : t_wrap

    // protected write ignored; protect raised after stop changes nothing
    task automatic t_protect();
        wp = 1'b1;
        wr(11'h5A2, {8'h99});
        chk_bit(busy, 1'b0, "no programming when protected");
        poll(11'h5A2, 1'b0);
        wp = 1'b0;
        wr(11'h5A2, {8'h77});
        wp = 1'b1;
        poll(11'h5A2, 1'b1);
        wp = 1'b0;
        addr_ph(11'h5A2);
        rd(11'h5A2, {8'h77});
        tw_master_i.stop();
    endtask : t_protect

    // foreign type code is refused and the engine stays usable
    task automatic t_mismatch();
        logic ack;
        tw_master_i.start();
        tw_master_i.wbyte({~TYPE_ID, 3'b101, 1'b0}, ack);
        chk_bit(ack, 1'b0, "foreign type nack");
        addr_ph(11'h5A2);
        rd(11'h5A2, {8'h77});
        tw_master_i.stop();
    endtask : t_mismatch

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        wp = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        tw_master_i.hw(4);
        t_byte();
        t_page();
        t_wrap();
        t_protect();
        t_mismatch();
        finish_test();
    end
endmodule : test_serial_eeprom_rw_engine

bind serial_eeprom_rw_engine eeprom_checker #(.WR_CNT(WR_CNT)) eeprom_checker_i (
    .clk(clk), .nrst(nrst), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_pin(wp_pin), .busy(busy));
